// ===== hdl/cpu_mode_pkg.sv
// Constants and carrier types for the CPU mode and memory map block
package cpu_mode_pkg;
  localparam logic [11:0] stk_bank_addr        = 12'h0f84;
  localparam logic [3:0]  stk_bank_reset_value = 4'h8;
  localparam int          stk_bank_mode_bit    = 3;
  localparam int          stk_bank_zero_bit    = 2;
  localparam logic [1:0]  bank_0            = 2'h0;
  localparam logic [1:0]  bank_1            = 2'h1;
  localparam logic [2:0]  push_bytes_compat = 3'h2;
  localparam logic [2:0]  push_bytes_ext    = 3'h3;
  localparam logic [2:0]  call_cycles_compat  = 3'h3;
  localparam logic [2:0]  call_cycles_ext     = 3'h4;
  localparam logic [2:0]  fcall_cycles_compat = 3'h2;
  localparam logic [2:0]  fcall_cycles_ext    = 3'h3;
  localparam logic [14:0] compat_rom_limit  = 15'h4000;
  localparam logic [12:0] vec_reset         = 13'h0000;
  localparam logic [12:0] vec_timer_b4      = 13'h0002;
  localparam logic [12:0] vec_ext_a         = 13'h0004;
  localparam logic [12:0] vec_serial        = 13'h0008;
  localparam logic [12:0] vec_timer_a       = 13'h000a;
  localparam logic [12:0] vec_timer_bc      = 13'h000c;
  localparam logic [12:0] vec_last          = 13'h000d;
  localparam logic [12:0] table_first       = 13'h0020;
  localparam logic [12:0] table_last        = 13'h007f;
  localparam logic [11:0] ram_last          = 12'h01ff;
  localparam logic [11:0] periph_first      = 12'h0f80;
  localparam logic [11:0] periph_last       = 12'h0fff;
  localparam int          rom_words_default = 8192;

  typedef enum logic [2:0] {
    st_idle      = 3'b000,
    st_vec_hi    = 3'b001,
    st_vec_lo    = 3'b010,
    st_done      = 3'b011
  } vec_state_t;

  typedef enum logic [2:0] {
    src_reset    = 3'b000,
    src_timer_b4 = 3'b001,
    src_ext_a    = 3'b010,
    src_serial   = 3'b011,
    src_timer_a  = 3'b100,
    src_timer_bc = 3'b101
  } vec_src_t;

  typedef struct packed {
    logic        mem_bank_en;
    logic        reg_bank_en;
    logic [12:0] start;
  } vec_entry_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [3:0]  wdata;
  } dmem_req_t;
endpackage

// ===== hdl/cpu_mode_ctrl.sv
// CPU mode select register, mode-dependent call behaviour and memory map decode
//
// Notes on behaviour
// RQ1 - Bit 3 of stack bank select chooses mode: one compat, zero extended.
// RQ2 - Calls push two bytes in compat mode, three bytes in extended mode.
// RQ3 - Extended absolute branch and call execute only in extended mode.
// RQ4 - Absolute call 3/4 cycles; fast call 2/3 cycles, compat/extended.
// RQ5 - Compat mode limits program memory to 16 Kbytes; extended has no limit.
// RQ6 - Software should prefer compat mode for RAM efficiency or speed.
// RQ7 - Stack bank select is 4-bit, written by nibble access at F84H.
// RQ8 - Software initialises register to 100x or 000x at program start.
// RQ9 - Low two bits pick stack bank 0 or 1; other values prohibited.
// RQ10 - Software always writes zero to bit 2.
// RQ11 - Reset sets mode bit, so the CPU starts in compat mode.
// RQ12 - Reset fetches start address and bank enables from 0000H and 0001H.
// RQ13 - Vectors 0002H to 000DH give interrupt start address and bank enables.
// RQ14 - Vector byte one: bank enables, zero, high 5 bits; byte two low 8.
// RQ15 - Vector assignment: 0002H, 0004H, 0008H, 000AH, 000CH per source.
// RQ16 - Program memory 0020H to 007FH is the table-indexed execute table.
// RQ17 - One-byte table-indexed execute stands for a longer referenced instruction.
// RQ18 - Program memory is 8 bits wide with 4096, 6144 or 8192 locations.
// RQ19 - Data memory holds 512 four-bit words at 000H to 1FFH.
// RQ20 - Peripheral hardware words occupy F80H to FFFH.
// RQ21 - Register-pair indexed branches replace only the low eight PC bits.
// RQ22 - Stack bank supplies upper data address bit for stack accesses.
module cpu_mode_ctrl
  import cpu_mode_pkg::*;
#(
  parameter int rom_words = rom_words_default
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Data memory access from the CPU core
  input  wire dmem_req_t   dmem_req,
  output logic [3:0]       dmem_rdata,
  output logic             ram_sel,
  output logic             periph_sel,
  output logic             stk_bank_sel,
  // Stack address request
  input  wire logic [7:0]  stack_ptr,
  output logic [8:0]       stack_addr,
  // Instruction decode requests
  input  wire logic        ext_branch_req,
  input  wire logic        ext_call_req,
  input  wire logic        abs_call_req,
  input  wire logic        fast_call_req,
  input  wire logic        pc_low_branch_req,
  input  wire logic [7:0]  pc_low_value,
  input  wire logic [12:0] pc_in,
  input  wire logic [12:0] pc_fetch,
  output logic             compat_mode,
  output logic             extended_mode,
  output logic             ext_instr_ok,
  output logic             illegal_instr,
  output logic [2:0]       push_bytes,
  output logic [2:0]       call_cycles,
  output logic [12:0]      pc_low_target,
  output logic             in_table_area,
  output logic             pc_out_of_range,
  // Vector fetch
  input  wire logic        vec_start,
  input  wire vec_src_t    vec_src,
  output logic [12:0]      rom_addr,
  output logic             rom_rd,
  input  wire logic [7:0]  rom_data,
  output vec_entry_t       vec_entry,
  output logic             vec_valid,
  output logic             vec_busy
);

  typedef struct packed {
    logic [3:0]  bank_sel;
    logic        extm;
    logic        busy;
    vec_state_t  vst;
    logic [12:0] vaddr;
    logic        memory_bank_enable_bit;
    logic        register_bank_enable_bit;
    logic [4:0]  hi;
    vec_entry_t  ventry;
    logic        vvalid;
    logic        rd;
    logic [3:0]  rdata;
    logic        ramsel;
    logic        persel;
    logic        bankhit;
    logic [8:0]  saddr;
    logic        ext_ok;
    logic        illegal;
    logic [2:0]  pbytes;
    logic [2:0]  ccycles;
    logic [12:0] pctgt;
    logic        tbl;
    logic        oor;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [12:0] vec_addr_of(input vec_src_t src);
    unique case (src)
      src_reset:    vec_addr_of = vec_reset;
      src_timer_b4: vec_addr_of = vec_timer_b4;
      src_ext_a:    vec_addr_of = vec_ext_a;
      src_serial:   vec_addr_of = vec_serial;
      src_timer_a:  vec_addr_of = vec_timer_a;
      src_timer_bc: vec_addr_of = vec_timer_bc;
      default:      vec_addr_of = vec_reset;
    endcase
  endfunction

  function automatic logic in_range12(input logic [11:0] a,
                                      input logic [11:0] lo,
                                      input logic [11:0] hi);
    in_range12 = (a >= lo) && (a <= hi);
  endfunction

  logic compat;
  logic [15:0] rom_limit;

  always_comb begin
    s_next = s_reg;
    compat = s_reg.bank_sel[stk_bank_mode_bit];  // see RQ1
    // Compat mode caps the reachable program space; the smaller of both applies
    rom_limit = (compat && (32'(rom_words) > 32'(compat_rom_limit)))
                ? 16'(compat_rom_limit) : 16'(rom_words);  // see RQ5 see RQ18

    // Nibble access to the data space
    s_next.ramsel = in_range12(dmem_req.addr, 12'h000, ram_last);       // see RQ19
    s_next.persel = in_range12(dmem_req.addr, periph_first, periph_last);  // see RQ20
    s_next.bankhit = (dmem_req.addr == stk_bank_addr);
    if (dmem_req.wr && (dmem_req.addr == stk_bank_addr)) begin
      // Bit 2 is held at zero whatever is written, so prohibited writes cannot set it
      s_next.bank_sel = dmem_req.wdata & ~(4'h1 << stk_bank_zero_bit);  // see RQ7 see RQ10
    end
    s_next.rdata = (dmem_req.rd && (dmem_req.addr == stk_bank_addr)) ? s_reg.bank_sel : 4'h0;

    // Stack bank is the ninth data address bit; bank codes above 1 fold to bit 0
    s_next.saddr = {s_reg.bank_sel[0], stack_ptr};  // see RQ9 see RQ22

    s_next.ext_ok  = !compat;  // see RQ3
    s_next.illegal = compat && (ext_branch_req || ext_call_req);  // see RQ3
    s_next.pbytes  = compat ? push_bytes_compat : push_bytes_ext;  // see RQ2
    if (fast_call_req) begin
      s_next.ccycles = compat ? fcall_cycles_compat : fcall_cycles_ext;  // see RQ4
    end else if (abs_call_req) begin
      s_next.ccycles = compat ? call_cycles_compat : call_cycles_ext;  // see RQ4
    end else begin
      s_next.ccycles = 3'h0;
    end
    if (pc_low_branch_req) begin
      s_next.pctgt = {pc_in[12:8], pc_low_value};  // see RQ21
    end
    // Table-indexed execute fetches one byte from here standing for a longer one
    s_next.tbl = (pc_fetch >= table_first) && (pc_fetch <= table_last);  // see RQ16 see RQ17
    s_next.oor = 16'(pc_fetch) >= rom_limit;  // see RQ5 see RQ18

    // Vector fetch: first byte has bank enables and high bits, second low bits
    s_next.vvalid = 1'b0;
    s_next.rd     = 1'b0;
    unique case (s_reg.vst)
      st_idle: begin
        if (vec_start) begin
          s_next.vaddr = vec_addr_of(vec_src);  // see RQ12 see RQ13 see RQ15
          s_next.rd    = 1'b1;
          s_next.vst   = st_vec_hi;
        end
      end
      st_vec_hi: begin
        s_next.memory_bank_enable_bit   = rom_data[7];  // see RQ14
        s_next.register_bank_enable_bit   = rom_data[6];
        s_next.hi    = rom_data[4:0];
        s_next.vaddr = s_reg.vaddr + 13'h0001;
        s_next.rd    = 1'b1;
        s_next.vst   = st_vec_lo;
      end
      st_vec_lo: begin
        s_next.ventry = '{mem_bank_en: s_reg.memory_bank_enable_bit, reg_bank_en: s_reg.register_bank_enable_bit,
                          start: {s_reg.hi, rom_data}};  // see RQ14
        s_next.vvalid = 1'b1;
        s_next.vst    = st_done;
      end
      st_done: begin
        s_next.vst = st_idle;
      end
      default: s_next.vst = st_idle;
    endcase
    // Kept as flops so that every output leaves straight from a register
    s_next.busy = (s_next.vst != st_idle);
    s_next.extm = ~s_next.bank_sel[stk_bank_mode_bit];  // see RQ1
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.bank_sel <= stk_bank_reset_value;  // see RQ11
      s_reg.vst   <= st_idle;
      s_reg.pbytes <= push_bytes_compat;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dmem_rdata      = s_reg.rdata;
  assign ram_sel         = s_reg.ramsel;
  assign periph_sel      = s_reg.persel;
  assign stk_bank_sel    = s_reg.bankhit;
  assign stack_addr      = s_reg.saddr;
  assign compat_mode     = s_reg.bank_sel[stk_bank_mode_bit];
  assign extended_mode   = s_reg.extm;
  assign ext_instr_ok    = s_reg.ext_ok;
  assign illegal_instr   = s_reg.illegal;
  assign push_bytes      = s_reg.pbytes;
  assign call_cycles     = s_reg.ccycles;
  assign pc_low_target   = s_reg.pctgt;
  assign in_table_area   = s_reg.tbl;
  assign pc_out_of_range = s_reg.oor;
  assign rom_addr        = s_reg.vaddr;
  assign rom_rd          = s_reg.rd;
  assign vec_entry       = s_reg.ventry;
  assign vec_valid       = s_reg.vvalid;
  assign vec_busy        = s_reg.busy;

endmodule

// ===== testbench/cpu_mode_ctrl_monitor.sv
// Concurrent checks on the mode, call, stack and vector ports
module cpu_mode_ctrl_monitor
  import cpu_mode_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Requests from the core
  input wire dmem_req_t   dmem_req,
  input wire logic [7:0]  stack_ptr,
  input wire logic        ext_call_req,
  input wire logic        fast_call_req,
  input wire logic        pc_low_branch_req,
  input wire logic [7:0]  pc_low_value,
  input wire logic [12:0] pc_in,
  input wire logic        vec_start,
  // Block outputs
  input wire logic [8:0]  stack_addr,
  input wire logic [12:0] pc_low_target,
  input wire logic        compat_mode,
  input wire logic        illegal_instr,
  input wire logic [2:0]  push_bytes,
  input wire logic [2:0]  call_cycles,
  input wire logic        vec_busy,
  input wire logic        rom_rd,
  input wire logic [12:0] rom_addr,
  input wire logic        vec_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Slices go through nets so that $past only ever sees a whole signal
  wire logic        new_mode = dmem_req.wdata[stk_bank_mode_bit];
  wire logic        sbs_wr   = dmem_req.wr && (dmem_req.addr == stk_bank_addr);
  wire logic [12:0] pcl_exp  = {pc_in[12:8], pc_low_value};
  sequence s_two_bytes;
    rom_rd && vec_busy ##1 rom_rd && (rom_addr == $past(rom_addr) + 13'h0001);
  endsequence
  sequence s_finish;
    vec_valid ##1 !vec_busy;
  endsequence
  a_mode_from_write: assert property (sbs_wr |=> compat_mode == $past(new_mode))
    else $error("mode output does not follow written mode bit");
  a_push_by_mode: assert property (push_bytes == ($past(compat_mode) ? 3'h2 : 3'h3))
    else $error("push byte count wrong for mode");
  a_ext_call_refused: assert property (ext_call_req |=> illegal_instr == $past(compat_mode))
    else $error("extended call legality wrong");
  a_fast_call_len: assert property (fast_call_req |=> call_cycles == ($past(compat_mode) ? 3'h2 : 3'h3))
    else $error("fast call cycle count wrong");
  a_reset_compat_mode: assert property (disable iff (1'b0) rst |=> compat_mode && push_bytes == 3'h2)
    else $error("reset does not select compat mode");
  a_vec_fetch_walk: assert property (vec_start && !vec_busy |=> s_two_bytes ##1 s_finish)
    else $error("vector fetch sequence wrong");
  a_stack_low_addr: assert property (!$past(rst) |-> stack_addr[7:0] == $past(stack_ptr))
    else $error("stack address low bits wrong");
  a_pc_low_only: assert property (pc_low_branch_req |=> pc_low_target == $past(pcl_exp))
    else $error("indexed branch target wrong");
endmodule
bind cpu_mode_ctrl cpu_mode_ctrl_monitor mon (.clk, .rst, .dmem_req, .stack_ptr, .ext_call_req,
  .fast_call_req, .pc_low_branch_req, .pc_low_value, .pc_in, .vec_start, .stack_addr,
  .pc_low_target, .compat_mode, .illegal_instr, .push_bytes, .call_cycles, .vec_busy, .rom_rd,
  .rom_addr, .vec_valid);

// ===== testbench/cpu_mode_ctrl_tb.sv
// Self-checking bench for the CPU mode and memory map block
module cpu_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_mode_pkg::*;
  localparam int rom_words_tb = 4096;
  logic clk = 1'b0, rst = 1'b1, ext_branch_req = 1'b0, ext_call_req = 1'b0, abs_call_req = 1'b0;
  logic fast_call_req = 1'b0, pc_low_branch_req = 1'b0, vec_start = 1'b0;
  logic [7:0] stack_ptr = 8'h00, pc_low_value = 8'h00, rom_data;
  logic [12:0] pc_in = 13'h0000, pc_fetch = 13'h0000, pc_low_target, rom_addr;
  dmem_req_t dmem_req = '0;
  vec_src_t vec_src = src_reset;
  logic [3:0] dmem_rdata;
  logic ram_sel, periph_sel, stk_bank_sel, compat_mode, extended_mode, ext_instr_ok, illegal_instr;
  logic in_table_area, pc_out_of_range, rom_rd, vec_valid, vec_busy;
  logic [8:0] stack_addr;
  logic [2:0] push_bytes, call_cycles;
  vec_entry_t vec_entry;
  int bad_count = 0, n_compared = 0;
  // Even bytes carry bank enables and a zero bit, odd bytes a distinct low address
  assign rom_data = rom_addr[0] ? (rom_addr[7:0] ^ 8'h5a) : {3'b100, rom_addr[5:1]};
  cpu_mode_ctrl #(.rom_words(rom_words_tb)) dut (.clk, .rst, .dmem_req, .dmem_rdata, .ram_sel,
    .periph_sel, .stk_bank_sel, .stack_ptr, .stack_addr, .ext_branch_req, .ext_call_req,
    .abs_call_req,
    .fast_call_req, .pc_low_branch_req, .pc_low_value, .pc_in, .pc_fetch, .compat_mode,
    .extended_mode, .ext_instr_ok, .illegal_instr, .push_bytes, .call_cycles, .pc_low_target,
    .in_table_area, .pc_out_of_range, .vec_start, .vec_src, .rom_addr, .rom_rd, .rom_data,
    .vec_entry, .vec_valid, .vec_busy);
  always #2 clk = ~clk;
  task automatic step();
    @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic bank_access(input logic wr, input logic [11:0] a, input logic [3:0] v);
    dmem_req = '{wr, !wr, a, v};
    step();
    dmem_req = '0;
  endtask
  task automatic t_reset();
    chk(compat_mode, 1'b1);
    chk(push_bytes, push_bytes_compat);
    bank_access(1'b0, stk_bank_addr, 4'h0);
    chk(dmem_rdata, stk_bank_reset_value);
  endtask
  task automatic t_modes();
    logic [3:0] v;
    for (int m = 0; m < 2; m++) begin
      // Compat pass runs last, left in place as the faster mode
      v = m ? 4'h9 : 4'h5;
      bank_access(1'b1, stk_bank_addr, v);
      stack_ptr = 8'ha5;
      step();
      chk(extended_mode, m == 0);
      chk(push_bytes, m ? 3'h2 : 3'h3);
      chk(stack_addr, {v[0], 8'ha5});
      bank_access(1'b0, stk_bank_addr, 4'h0);
      chk(dmem_rdata, v & 4'hb);
      {fast_call_req, abs_call_req, ext_call_req, ext_branch_req} = 4'hf;
      step();
      chk(call_cycles, m ? 3'h2 : 3'h3);
      chk({illegal_instr, ext_instr_ok}, m ? 2'h2 : 2'h1);
      {fast_call_req, ext_call_req, ext_branch_req} = 3'h0;
      step();
      chk(call_cycles, m ? 3'h3 : 3'h4);
      abs_call_req = 1'b0;
    end
  endtask
  task automatic t_vectors();
    logic [12:0] base [6] = '{13'h0000, 13'h0002, 13'h0004, 13'h0008, 13'h000a, 13'h000c};
    for (int i = 0; i < 6; i++) begin
      vec_src = vec_src_t'(i);
      vec_start = 1'b1;
      step();
      chk({rom_rd, rom_addr}, {1'b1, base[i]});
      step();
      vec_start = 1'b0;
      chk(rom_addr, base[i] + 13'h0001);
      step();
      chk({vec_valid, vec_entry}, {3'b110, base[i][5:1], {base[i][7:1], 1'b1} ^ 8'h5a});
      repeat (2) step();
    end
  endtask
  task automatic t_maps();
    logic [11:0] a [5] = '{12'h01ff, 12'h0200, 12'h0f80, 12'h0f84, 12'h0fff};
    logic [12:0] p [6] = '{13'h001f, 13'h0020, 13'h007f, 13'h0080, 13'h0fff, 13'h1000};
    foreach (a[i]) begin
      bank_access(1'b0, a[i], 4'h0);
      chk({ram_sel, periph_sel, stk_bank_sel},
          {a[i] <= ram_last, a[i] >= periph_first, a[i] == stk_bank_addr});
    end
    foreach (p[i]) begin
      pc_fetch = p[i];
      step();
      chk({in_table_area, pc_out_of_range}, {p[i] >= table_first && p[i] <= table_last, p[i] >= 13'h1000});
    end
    {pc_in, pc_low_value, pc_low_branch_req} = {13'h1abc, 8'h34, 1'b1};
    step();
    {pc_in, pc_low_branch_req} = '0;
    step();
    chk(pc_low_target, 13'h1a34);
  endtask
  initial begin
    repeat (3) step();
    rst = 1'b0;
    t_reset();
    t_modes();
    t_vectors();
    t_maps();
    give_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule
